// ===== logic/ata_cmd_pkg.sv
// shared constants and types for the command decoder
package ata_cmd_pkg;

    // ****************************************
    // register word addresses
    // ****************************************
    localparam logic [3:0] A_DATA = 4'h0;
    localparam logic [3:0] A_FEAT_ERR = 4'h1;
    localparam logic [3:0] A_SCOUNT = 4'h2;
    localparam logic [3:0] A_SNUM = 4'h3;
    localparam logic [3:0] A_CYL_LO = 4'h4;
    localparam logic [3:0] A_CYL_HI = 4'h5;
    localparam logic [3:0] A_DRV_HEAD = 4'h6;
    localparam logic [3:0] A_CMD_STAT = 4'h7;
    localparam logic [3:0] A_CTRL_ALT = 4'h8;

    // ****************************************
    // field positions and codes
    // ****************************************
    localparam int DH_DRIVE_BIT = 4;
    localparam int DH_LBA_BIT = 6;
    localparam int CTRL_SRST_BIT = 2;
    localparam int CTRL_NIEN_BIT = 1;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] DIAG_PASS = 8'h01;
    localparam logic [7:0] DIAG_FAIL = 8'h05;
    localparam logic [7:0] PWR_ACTIVE = 8'hFF;
    localparam logic [7:0] PWR_STANDBY = 8'h00;
    localparam logic [7:0] SNUM_MAX = 8'h20;
    localparam logic [3:0] HEAD_MAX = 4'h3;
    localparam logic [8:0] BLOCK_WORDS = 9'h100;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_SCOUNT = 8'h01;
    localparam logic [7:0] RST_SNUM = 8'h01;
    localparam logic [7:0] RST_ERR = 8'h01;
    localparam logic [7:0] RST_CTRL = 8'h08;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 250;
    localparam int BUSY_NS = 40;
    localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        CL_BAD, CL_NOP, CL_PWRQ, CL_DIAG, CL_IDENT, CL_IDLE,
        CL_IDLEIMM, CL_STBY, CL_FORMAT, CL_MEDIA
    } cmd_class_e;

    typedef enum logic [4:0] {
        ST_READY = 5'b00001,
        ST_BUSY = 5'b00010,
        ST_MEDIA = 5'b00100,
        ST_DOUT = 5'b01000,
        ST_DIN = 5'b10000
    } state_e;

    typedef struct packed {
        logic [7:0] opcode;
        logic lba_mode;
        logic [7:0] count;
        logic [7:0] sector;
        logic [15:0] cylinder;
        logic [3:0] head;
        logic [7:0] fill;
    } media_req_s;

endpackage : ata_cmd_pkg

// ===== logic/ata_command_decoder.sv
// task-file command decoder with avalon register slave and identify block
module ata_command_decoder
    import ata_cmd_pkg::*;
#(
    parameter logic [15:0] CYLS = 16'd1000,
    parameter logic [15:0] HEADS = 16'd4,
    parameter logic [15:0] SPT = 16'd32,
    parameter logic [7:0] FILL_PATTERN = 8'h00,
    // identity text: arbitrary values
    parameter logic [159:0] SERIAL_TEXT = "SN000000000000000001",
    parameter logic [63:0] FW_TEXT = "REV00001",
    parameter logic [319:0] MODEL_TEXT = "GENERIC SOLID STATE DISK                "
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_slave_strap,
    input wire logic i_selftest_ok,
    output logic o_media_valid,
    output media_req_s o_media_req,
    input wire logic i_media_done,
    input wire logic i_media_error,
    output logic o_intrq
);

    localparam logic [31:0] TOTAL = 32'(CYLS) * 32'(HEADS) * 32'(SPT);
    localparam int TW = $clog2(BUSY_CYC + 1);

    // ****************************************
    // decode functions
    // ****************************************
    function automatic cmd_class_e classify(input logic [7:0] op);
        cmd_class_e c;
        c = CL_BAD;
        if (op[7:4] == 4'h1 || op[7:4] == 4'h7) begin
            c = CL_NOP;
        end else begin
            case (op)
                8'hE5, 8'h98: c = CL_PWRQ;
                8'h90: c = CL_DIAG;
                8'hEC: c = CL_IDENT;
                8'hE3, 8'h97: c = CL_IDLE;
                8'hE1, 8'h95: c = CL_IDLEIMM;
                8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99: c = CL_STBY;
                8'h50: c = CL_FORMAT;
                8'hC0, 8'hC4, 8'hC5, 8'hE4, 8'hE8, 8'h3C: c = CL_MEDIA;
                8'hCD, 8'h38: c = CL_MEDIA;
                8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41:
                    c = CL_MEDIA;
                8'h91, 8'h03, 8'hEF, 8'hC6, 8'h87, 8'hF5: c = CL_NOP;
                default: c = CL_BAD;
            endcase
        end
        return c;
    endfunction : classify

    function automatic logic [15:0] ident_word(input logic [7:0] w);
        logic [15:0] r;
        int i;
        r = 16'h0000;
        i = int'(w);
        if (i >= 10 && i <= 19) begin
            r = SERIAL_TEXT[159 - 16 * (i - 10) -: 16];
        end else if (i >= 23 && i <= 26) begin
            r = FW_TEXT[63 - 16 * (i - 23) -: 16];
        end else if (i >= 27 && i <= 46) begin
            r = MODEL_TEXT[319 - 16 * (i - 27) -: 16];
        end else begin
            case (w)
                8'd0: r = 16'h044A;
                8'd1, 8'd54: r = CYLS;
                8'd3, 8'd55: r = HEADS;
                8'd6, 8'd56: r = SPT;
                8'd7: r = TOTAL[31:16];
                8'd8: r = TOTAL[15:0];
                8'd57: r = TOTAL[15:0];
                8'd58: r = TOTAL[31:16];
                8'd22: r = 16'h0004;
                8'd47: r = 16'h0001;
                8'd49: r = 16'h0200;
                8'd51: r = 16'h0200;
                8'd53: r = 16'h0003;
                8'd59: r = 16'h0101;
                8'd60: r = TOTAL[15:0];
                8'd61: r = TOTAL[31:16];
                8'd64: r = 16'h0003;
                8'd67, 8'd68: r = 16'h0078;
                default: r = 16'h0000;
            endcase
        end
        return r;
    endfunction : ident_word

    // ****************************************
    // state
    // ****************************************
    state_e st_q;
    cmd_class_e cls_q;
    logic ack_q;
    logic wreq_q;
    logic [31:0] rdata_q;
    logic [7:0] feat_q, scount_q, snum_q, cyl_lo_q, cyl_hi_q, dh_q, ctrl_q;
    logic [7:0] err_q, pwr_q, op_q;
    logic apd_en_q, err_flag_q, dsc_q, irq_pend_q, intrq_q;
    logic [TW-1:0] tmr_q;
    logic [7:0] word_q;
    logic media_valid_q;
    media_req_s media_req_q;
    logic strap1_q, strap2_q, strap3_q, strap_q;

    // ****************************************
    // bus decode
    // ****************************************
    wire req = i_avs_read | i_avs_write;
    wire ack_d = req & ~ack_q;
    wire wr_acc = i_avs_write & ack_q;
    wire rd_acc = i_avs_read & ack_q;
    wire [7:0] wd = i_avs_writedata[7:0];
    wire busy = (st_q == ST_BUSY) || (st_q == ST_MEDIA);
    wire soft_rst = ctrl_q[CTRL_SRST_BIT];
    wire tf_we = wr_acc & ~busy;
    wire selected = dh_q[DH_DRIVE_BIT] == strap_q;
    cmd_class_e new_cls;
    assign new_cls = classify(wd);
    wire cmd_wr = tf_we & (i_avs_address == A_CMD_STAT);
    wire cmd_go = cmd_wr & (st_q == ST_READY) & (selected | new_cls == CL_DIAG);
    wire chs = ~dh_q[DH_LBA_BIT];
    wire bad_addr = chs & (snum_q == 8'h00 | snum_q > SNUM_MAX | dh_q[3:0] > HEAD_MAX);
    wire addr_cmd = new_cls == CL_MEDIA || new_cls == CL_FORMAT;
    cmd_class_e go_cls;
    assign go_cls = (addr_cmd && bad_addr) ? CL_BAD : new_cls;
    wire data_rd = rd_acc & (i_avs_address == A_DATA) & (st_q == ST_DOUT);
    wire data_wr = wr_acc & (i_avs_address == A_DATA) & (st_q == ST_DIN);
    wire last_word = word_q == BLOCK_WORDS[7:0] - 8'h01;
    wire stat_rd = rd_acc & (i_avs_address == A_CMD_STAT);
    wire tmr_end = (st_q == ST_BUSY) && (tmr_q == '0);
    wire drq = (st_q == ST_DOUT) || (st_q == ST_DIN);
    wire [7:0] status = busy ? 8'h80 : {1'b0, 1'b1, 1'b0, dsc_q, drq, 2'b00, err_flag_q};
    // with-retry and without-retry share one operation code
    wire pair_op = (wd[7:4] == 4'h2 || wd[7:4] == 4'h3 || wd[7:4] == 4'h4) && wd[3:2] == 2'b00;
    wire [7:0] base_op = pair_op ? {wd[7:1], 1'b0} : wd;
    wire [15:0] rd_mux =
        (i_avs_address == A_DATA) ? (st_q == ST_DOUT ? ident_word(word_q) : 16'h0000) :
        (i_avs_address == A_FEAT_ERR) ? {8'h00, err_q} :
        (i_avs_address == A_SCOUNT) ? {8'h00, scount_q} :
        (i_avs_address == A_SNUM) ? {8'h00, snum_q} :
        (i_avs_address == A_CYL_LO) ? {8'h00, cyl_lo_q} :
        (i_avs_address == A_CYL_HI) ? {8'h00, cyl_hi_q} :
        (i_avs_address == A_DRV_HEAD) ? {8'h00, dh_q} :
        (i_avs_address == A_CMD_STAT || i_avs_address == A_CTRL_ALT) ? {8'h00, status} :
        16'h0000;
    // interrupt set on completion wins over a clearing status read
    wire irq_set = (tmr_end && cls_q != CL_FORMAT && cls_q != CL_MEDIA)
        || (st_q == ST_MEDIA && i_media_done);
    wire irq_pend_d = irq_set | (irq_pend_q & ~stat_rd & ~soft_rst);

    // ****************************************
    // avalon slave
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ack_q <= 1'b0;
            wreq_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            wreq_q <= ~ack_d;
            rdata_q <= ack_d ? {16'h0000, rd_mux} : rdata_q;
        end
    end

    // ****************************************
    // strap synchroniser
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            strap1_q <= 1'b0;
            strap2_q <= 1'b0;
            strap3_q <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            strap1_q <= i_slave_strap;
            strap2_q <= strap1_q;
            strap3_q <= strap2_q;
            strap_q <= (strap2_q == strap3_q) ? strap3_q : strap_q;
        end
    end

    // ****************************************
    // task file and device control
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ctrl_q <= RST_CTRL;
        end else if (wr_acc && i_avs_address == A_CTRL_ALT) begin
            ctrl_q <= wd;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || soft_rst) begin
            feat_q <= 8'h00;
            snum_q <= RST_SNUM;
            cyl_lo_q <= 8'h00;
            cyl_hi_q <= 8'h00;
            dh_q <= 8'h00;
        end else if (tf_we) begin
            feat_q <= (i_avs_address == A_FEAT_ERR) ? wd : feat_q;
            snum_q <= (i_avs_address == A_SNUM) ? wd : snum_q;
            cyl_lo_q <= (i_avs_address == A_CYL_LO) ? wd : cyl_lo_q;
            cyl_hi_q <= (i_avs_address == A_CYL_HI) ? wd : cyl_hi_q;
            dh_q <= (i_avs_address == A_DRV_HEAD) ? wd : dh_q;
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || soft_rst) begin
            st_q <= ST_READY;
            cls_q <= CL_NOP;
            op_q <= 8'h00;
            tmr_q <= '0;
            word_q <= 8'h00;
            scount_q <= RST_SCOUNT;
            err_q <= RST_ERR;
            err_flag_q <= 1'b0;
            dsc_q <= 1'b1;
            pwr_q <= PWR_ACTIVE;
            apd_en_q <= 1'b0;
            media_valid_q <= 1'b0;
            media_req_q <= '0;
        end else begin
            case (st_q)
                ST_READY: begin
                    if (tf_we && i_avs_address == A_SCOUNT) begin
                        scount_q <= wd;
                    end
                    if (cmd_go) begin
                        st_q <= ST_BUSY;
                        cls_q <= go_cls;
                        op_q <= base_op;
                        tmr_q <= TW'(BUSY_CYC - 1);
                        err_flag_q <= 1'b0;
                        err_q <= 8'h00;
                    end
                end
                ST_BUSY: begin
                    tmr_q <= tmr_q - TW'(1);
                    if (tmr_end) begin
                        st_q <= ST_READY;
                        case (cls_q)
                            CL_BAD: begin
                                err_q <= (op_q == 8'h90) ? err_q : ERR_ABORT;
                                err_flag_q <= 1'b1;
                            end
                            CL_PWRQ: scount_q <= pwr_q;
                            CL_DIAG: err_q <= i_selftest_ok ? DIAG_PASS : DIAG_FAIL;
                            CL_IDENT: begin
                                st_q <= ST_DOUT;
                                word_q <= 8'h00;
                            end
                            CL_IDLE: begin
                                pwr_q <= PWR_ACTIVE;
                                apd_en_q <= scount_q != 8'h00;
                            end
                            CL_IDLEIMM: pwr_q <= PWR_ACTIVE;
                            CL_STBY: pwr_q <= PWR_STANDBY;
                            CL_FORMAT: begin
                                st_q <= ST_DIN;
                                word_q <= 8'h00;
                            end
                            CL_MEDIA: begin
                                st_q <= ST_MEDIA;
                                media_valid_q <= 1'b1;
                                media_req_q <= '{op_q, dh_q[DH_LBA_BIT], scount_q, snum_q,
                                    {cyl_hi_q, cyl_lo_q}, dh_q[3:0], 8'h00};
                            end
                            default: st_q <= ST_READY;
                        endcase
                    end
                end
                ST_DOUT: begin
                    if (data_rd) begin
                        word_q <= word_q + 8'h01;
                        st_q <= last_word ? ST_READY : ST_DOUT;
                    end
                end
                ST_DIN: begin
                    if (data_wr) begin
                        word_q <= word_q + 8'h01; // data itself is dropped
                        if (last_word) begin
                            st_q <= ST_MEDIA;
                            media_valid_q <= 1'b1;
                            media_req_q <= '{op_q, dh_q[DH_LBA_BIT], scount_q, snum_q,
                                {cyl_hi_q, cyl_lo_q}, dh_q[3:0], FILL_PATTERN};
                        end
                    end
                end
                ST_MEDIA: begin
                    if (i_media_done) begin
                        st_q <= ST_READY;
                        media_valid_q <= 1'b0;
                        err_flag_q <= i_media_error;
                        err_q <= i_media_error ? ERR_ABORT : 8'h00;
                    end
                end
                default: st_q <= ST_READY;
            endcase
        end
    end

    // ****************************************
    // interrupt line
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            irq_pend_q <= 1'b0;
            intrq_q <= 1'b0;
        end else begin
            irq_pend_q <= irq_pend_d;
            intrq_q <= irq_pend_d & ~ctrl_q[CTRL_NIEN_BIT] & selected;
        end
    end

    assign o_avs_readdata = rdata_q;
    assign o_avs_waitrequest = wreq_q;
    assign o_media_valid = media_valid_q;
    assign o_media_req = media_req_q;
    assign o_intrq = intrq_q;

endmodule : ata_command_decoder

// ===== sim/ata_cmd_checker.sv
// port-level assertions for the command decoder
module ata_cmd_checker
    import ata_cmd_pkg::*;
#(
    parameter logic [7:0] FILL_PATTERN = 8'h00
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic o_media_valid,
    input wire media_req_s o_media_req,
    input wire logic i_media_done,
    input wire logic o_intrq
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ****************************************
    // bus handshake
    // ****************************************
    wait_one_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("request not answered after one wait");
    wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("answer longer than one cycle");
    data_width_a: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    rst_vals_a: assert property (@(posedge i_ref_clk) disable iff (1'b0) !i_rst_n
        |=> o_avs_waitrequest && !o_media_valid && !o_intrq && o_avs_readdata == 32'h0)
        else $error("outputs not at reset values");

    // ****************************************
    // media requests and interrupt
    // ****************************************
    media_hold_a: assert property (o_media_valid && !i_media_done
        |=> o_media_valid && $stable(o_media_req)) else $error("media request moved");
    media_drop_a: assert property (o_media_valid && i_media_done |=> !o_media_valid)
        else $error("media request kept after done");
    retry_pair_a: assert property (o_media_valid |-> !(o_media_req.opcode inside
        {8'h21, 8'h23, 8'h31, 8'h33, 8'h41})) else $error("retry variant not merged");
    chs_range_a: assert property (o_media_valid && !o_media_req.lba_mode
        && o_media_req.opcode != 8'h50 |-> o_media_req.sector inside {[8'h01:SNUM_MAX]}
        && o_media_req.head <= HEAD_MAX) else $error("address outside range passed on");
    fill_pat_a: assert property (o_media_valid && o_media_req.opcode == 8'h50
        |-> o_media_req.fill == FILL_PATTERN) else $error("format fill wrong");
    intr_clear_a: assert property (i_avs_read && !o_avs_waitrequest && o_intrq
        && i_avs_address == A_CMD_STAT |-> ##[1:2] !o_intrq) else $error("intrq not cleared");
endmodule : ata_cmd_checker

bind ata_command_decoder ata_cmd_checker #(.FILL_PATTERN(FILL_PATTERN)) u_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_media_valid(o_media_valid),
    .o_media_req(o_media_req),
    .i_media_done(i_media_done),
    .o_intrq(o_intrq)
);

// ===== sim/media_model.sv
// behavioural media engine answering decoder requests
module media_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [7:0] i_delay,
    input wire logic i_fail,
    output logic o_done,
    output logic o_error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || !i_valid || o_done) begin
            cnt_q <= 8'h00;
            o_done <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            o_done <= (cnt_q == i_delay);
        end
    end
    // error line meaningless outside done, so it shows the inverse
    assign o_error = o_done ? i_fail : ~i_fail;
endmodule : media_model

// ===== sim/tb.sv
// self-checking bench for the command decoder
module tb
    import ata_cmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] v; logic on;} note_s;
    localparam logic [15:0] N_CYL = 16'h0040;
    localparam logic [15:0] N_HEAD = 16'h0004;
    localparam logic [15:0] N_SPT = 16'h0020;
    localparam logic [159:0] SER = "SER0123456789ABCDEFG";
    localparam logic [63:0] FWR = "FW-00042";
    localparam logic [319:0] MDL = {20{"QM"}};
    localparam logic [7:0] OK_OPS [12] = '{8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95,
        8'h91, 8'h03, 8'hEF, 8'hC6, 8'h87, 8'hF5};
    localparam logic [7:0] MOPS [16] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32,
        8'h33, 8'h40, 8'h41, 8'hC0, 8'hC4, 8'hC5, 8'hCD, 8'h38, 8'h3C};
    localparam logic [23:0] ERRS [4] = '{24'hFE01A0, 24'h2000A0, 24'h2021A0, 24'h3001A4};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic st_ok = 1'b1;
    logic fail = 1'b0;
    logic [7:0] dly = 8'h00;
    logic [15:0] cyl = 16'h0005;
    logic [31:0] rdata;
    logic wreq, valid, done, merr, intrq;
    logic valid_q = 1'b0;
    media_req_s req;
    note_s rq[$];
    media_req_s mq[$];
    int error_cnt = 0;
    int n_tests = 0;
    integer seed = 32'h51D4;

    ata_command_decoder #(.CYLS(N_CYL), .HEADS(N_HEAD), .SPT(N_SPT), .FILL_PATTERN(8'hFF),
        .SERIAL_TEXT(SER), .FW_TEXT(FWR), .MODEL_TEXT(MDL)) DUT (.i_ref_clk(clk),
        .i_rst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_slave_strap(1'b0), .i_selftest_ok(st_ok), .o_media_valid(valid),
        .o_media_req(req), .i_media_done(done), .i_media_error(merr), .o_intrq(intrq));
    media_model u_media (.i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_delay(dly),
        .i_fail(fail), .o_done(done), .o_error(merr));

    initial begin
        forever #2 clk = ~clk;
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    always @(posedge clk) begin
        valid_q <= valid;
        if (rd && !wreq && rq.size() > 0 && rq[0].on) check(rdata[15:0], rq[0].v);
        if (rd && !wreq && rq.size() > 0) void'(rq.pop_front());
        if (valid && !valid_q && mq.size() == 0) check(1'b1, 1'b0);
        if (valid && !valid_q && mq.size() > 0)
            check(req.opcode == 8'h50 ? req : {req[52:8], 8'h00}, mq.pop_front());
    end

    // ****************************************
    // bus and command tasks
    // ****************************************
    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d,
                       output logic [15:0] q);
        int k;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        addr <= a;
        wdata <= {16'h0, d};
        for (k = 0; k < 50 && (k == 0 || wreq); k++) @(posedge clk);
        if (wreq) begin
            error_cnt++;
            final_report();
        end
        q = rdata[15:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic wrt(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus(1'b1, a, d, q);
    endtask : wrt

    task automatic rdx(input logic [3:0] a, input logic [15:0] e, input logic on);
        logic [15:0] q;
        rq.push_back('{e, on});
        bus(1'b0, a, 16'h0, q);
    endtask : rdx

    task automatic poll(input logic [7:0] m);
        logic [15:0] q;
        int k;
        q = 16'h00FF;
        for (k = 0; k < 120 && (q[7:0] & m) != 8'h00; k++) begin
            rq.push_back('{16'h0, 1'b0});
            bus(1'b0, A_CTRL_ALT, 16'h0, q);
        end
        if ((q[7:0] & m) != 8'h00) begin
            error_cnt++;
            final_report();
        end
    endtask : poll

    task automatic cmd(input logic [7:0] op, input logic [7:0] sc, input logic [7:0] sn,
                       input logic [7:0] dh);
        wrt(A_SCOUNT, sc);
        wrt(A_SNUM, sn);
        wrt(A_CYL_LO, cyl[7:0]);
        wrt(A_CYL_HI, cyl[15:8]);
        wrt(A_DRV_HEAD, dh);
        wrt(A_CMD_STAT, op);
        poll(8'h80);
    endtask : cmd

    task automatic fin(input logic [15:0] st, input logic irq);
        repeat (3) @(posedge clk);
        check(intrq, irq);
        rdx(A_CMD_STAT, st, 1'b1);
        repeat (3) @(posedge clk);
        check(intrq, 1'b0);
    endtask : fin

    function automatic logic [16:0] idw(input int i);
        logic [31:0] t;
        t = N_CYL * N_HEAD * N_SPT;
        case (i)
            0: idw = 17'h1044A;
            7, 58, 61: idw = {1'b1, t[31:16]};
            8, 57, 60: idw = {1'b1, t[15:0]};
            22: idw = 17'h10004;
            47: idw = 17'h10001;
            49, 51: idw = 17'h10200;
            53, 64: idw = 17'h10003;
            54: idw = {1'b1, N_CYL};
            55: idw = {1'b1, N_HEAD};
            56: idw = {1'b1, N_SPT};
            59: idw = 17'h10101;
            67, 68: idw = 17'h10078;
            default: begin
                idw = (i == 2 || i == 9 || i == 48 || i == 50 || i == 52 || i == 62 || i == 63
                    || i == 65 || i == 66 || i >= 69) ? 17'h10000 : 17'h0;
                if (i >= 10 && i <= 19) idw = {1'b1, SER[159 - 16 * (i - 10) -: 16]};
                if (i >= 23 && i <= 26) idw = {1'b1, FWR[63 - 16 * (i - 23) -: 16]};
                if (i >= 27 && i <= 46) idw = {1'b1, MDL[319 - 16 * (i - 27) -: 16]};
            end
        endcase
    endfunction : idw

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [16:0] w;
        logic [7:0] op, sn, hd;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rdx(A_CMD_STAT, 16'h0050, 1'b1);
        rdx(A_FEAT_ERR, 16'h0001, 1'b1);
        rdx(A_SCOUNT, 16'h0001, 1'b1);
        rdx(4'hC, 16'h0000, 1'b1);
        cmd(8'hEC, 8'h01, 8'h01, 8'hA0);
        fin(16'h0058, 1'b1);
        for (int i = 0; i < 256; i++) begin
            w = idw(i);
            rdx(A_DATA, w[15:0], w[16]);
        end
        rdx(A_CMD_STAT, 16'h0050, 1'b1);
        for (int i = 0; i < 14; i++) begin
            op = (i < 12) ? OK_OPS[i] : {(i == 12) ? 4'h1 : 4'h7, 4'($random(seed))};
            cmd(op, 8'($random(seed)), 8'h01, 8'hA0);
            fin(16'h0050, 1'b1);
            if (i < 2) rdx(A_SCOUNT, 16'h00FF, 1'b1);
        end
        cmd(8'hE0, 8'h00, 8'h01, 8'hA0);
        fin(16'h0050, 1'b1);
        cmd(8'hE5, 8'h07, 8'h01, 8'hA0);
        fin(16'h0050, 1'b1);
        rdx(A_SCOUNT, 16'h0000, 1'b1);
        for (int i = 0; i < 4; i++) begin
            {op, sn, hd} = ERRS[i];
            cmd(op, 8'h01, sn, hd);
            fin(16'h0051, 1'b1);
            rdx(A_FEAT_ERR, 16'h0004, 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            st_ok <= (i == 0);
            cmd(8'h90, 8'h01, 8'h01, (i == 0) ? 8'hA0 : 8'hB0);
            repeat (3) @(posedge clk);
            check(intrq, i == 0);
            rdx(A_FEAT_ERR, (i == 0) ? 16'h0001 : 16'h0005, 1'b1);
            rdx(A_CMD_STAT, 16'h0, 1'b0);
        end
        for (int i = 0; i < 16; i++) begin
            op = MOPS[i];
            sn = 8'h01 + 8'($unsigned($random(seed)) % 32);
            hd = {(i % 4 == 2) ? 4'hE : 4'hA, 2'b00, 2'($random(seed))};
            cyl = 16'($unsigned($random(seed)) % 64);
            dly <= (i == 15) ? 8'hC8 : 8'($unsigned($random(seed)) % 24);
            fail <= (i == 5);
            w[7:0] = 8'($random(seed));
            mq.push_back('{{op[7:1], op[0] & !(op inside {8'h21, 8'h23, 8'h31, 8'h33, 8'h41})},
                hd[6], w[7:0], sn, cyl, hd[3:0], 8'h00});
            cmd(op, w[7:0], sn, hd);
            fin((i == 5) ? 16'h0051 : 16'h0050, 1'b1);
        end
        mq.push_back('{8'h50, 1'b0, 8'h01, 8'h01, cyl, 4'h2, 8'hFF});
        cmd(8'h50, 8'h01, 8'h01, 8'hA2);
        rdx(A_CTRL_ALT, 16'h0058, 1'b1);
        for (int i = 0; i < 256; i++) wrt(A_DATA, 16'($random(seed)));
        poll(8'h88);
        rdx(A_CTRL_ALT, 16'h0050, 1'b1);
        wrt(A_CTRL_ALT, 16'h0004);
        wrt(A_CTRL_ALT, 16'h0000);
        check(intrq, 1'b0);
        rdx(A_FEAT_ERR, 16'h0001, 1'b1);
        final_report();
    end
endmodule : tb
